// ==== hdl/packet_acl_filter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "acl_defs.vh"
// non-ipv4 groups reuse the destination address field for the ether-type
// (low 16 bits, any flag = dst-any); binding groups reuse source address
// for the bound ip and dst ip+mask low 48 bits for the bound mac.
module packet_acl_filter (
  // clock and reset
  input  wire         i_clock,
  input  wire         i_srst,
  // rule write port
  input  wire         i_wr_en,
  input  wire [7:0]   i_wr_group,
  input  wire         i_wr_valid,
  input  wire         i_wr_action,
  input  wire [1:0]   i_wr_type,
  input  wire         i_wr_vlan_any,
  input  wire [11:0]  i_wr_vid,
  input  wire         i_wr_src_any,
  input  wire [31:0]  i_wr_src_ip,
  input  wire [31:0]  i_wr_src_mask,
  input  wire         i_wr_dst_any,
  input  wire [31:0]  i_wr_dst_ip,
  input  wire [31:0]  i_wr_dst_mask,
  input  wire         i_wr_frag_en,
  input  wire         i_wr_frag,
  input  wire         i_wr_proto_any,
  input  wire [7:0]   i_wr_proto,
  input  wire         i_wr_l4_any,
  input  wire [15:0]  i_wr_l4_port,
  input  wire [4:0]   i_wr_in_port,
  // packet header in
  input  wire         i_pkt_valid,
  output reg          o_pkt_ready,
  input  wire [11:0]  i_pkt_vid,
  input  wire [4:0]   i_pkt_port,
  input  wire [15:0]  i_pkt_etype,
  input  wire [47:0]  i_pkt_src_mac,
  input  wire [31:0]  i_pkt_src_ip,
  input  wire [31:0]  i_pkt_dst_ip,
  input  wire         i_pkt_frag,
  input  wire [7:0]   i_pkt_proto,
  input  wire [15:0]  i_pkt_src_l4,
  input  wire [15:0]  i_pkt_dst_l4,
  // decision out
  output reg          o_dec_valid,
  output reg          o_dec_deny,
  output reg          o_dec_hit,
  output reg  [7:0]   o_dec_group
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SCAN = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [`ACL_E_W-1:0] table_mem [0:`ACL_GROUPS-1]; // [R1]
  reg [1:0]          state;
  reg [7:0]          idx;
  reg [11:0]         h_vid;
  reg [4:0]          h_port;
  reg [15:0]         h_etype;
  reg [47:0]         h_mac;
  reg [31:0]         h_sip;
  reg [31:0]         h_dip;
  reg                h_frag;
  reg [7:0]          h_proto;
  reg [15:0]         h_sl4;
  reg [15:0]         h_dl4;

  // masked compare; arbitrary mask bits, not a prefix
  function masked_eq;
    input [31:0] a;
    input [31:0] b;
    input [31:0] m;
    begin
      masked_eq = ((a ^ b) & m) == 32'h00000000; // [R6] [R7]
    end
  endfunction

  // whole-group match of one header against one entry; the header comes in
  // as arguments so that the caller is re-evaluated when the header changes
  function group_match;
    input [`ACL_E_W-1:0] e;
    input [11:0]         k_vid;
    input [4:0]          k_port;
    input [15:0]         k_etype;
    input [47:0]         k_mac;
    input [31:0]         k_sip;
    input [31:0]         k_dip;
    input                k_frag;
    input [7:0]          k_proto;
    input [15:0]         k_sl4;
    input [15:0]         k_dl4;
    reg                  vlan_ok;
    reg                  port_ok;
    reg                  ip_ok;
    reg                  l4_ok;
    reg [7:0]            pr;
    begin
      vlan_ok = e[`ACL_E_VANY] ||
                (e[`ACL_E_VID +: 12] == k_vid); // [R3]
      port_ok = (e[`ACL_E_INPORT +: 5] == 5'h00) ||
                (e[`ACL_E_INPORT +: 5] == k_port); // [R15]
      pr = e[`ACL_E_PROTO +: 8];
      // a port value applies to the transport that the protocol names;
      // with protocol any, either port may carry it
      if (e[`ACL_E_L4ANY])
        l4_ok = 1'b1;
      else if (k_proto == `ACL_PROTO_TCP &&
               (e[`ACL_E_PANY] || pr == `ACL_PROTO_TCP))
        l4_ok = (k_dl4 == e[`ACL_E_L4PORT +: 16]) ||
                (k_sl4 == e[`ACL_E_L4PORT +: 16]); // [R11] [R12]
      else if (k_proto == `ACL_PROTO_UDP &&
               (e[`ACL_E_PANY] || pr == `ACL_PROTO_UDP))
        l4_ok = (k_dl4 == e[`ACL_E_L4PORT +: 16]) ||
                (k_sl4 == e[`ACL_E_L4PORT +: 16]); // [R13] [R14]
      else
        l4_ok = 1'b0;
      ip_ok = (k_etype == `ACL_ETH_IPV4) &&
              (e[`ACL_E_SANY] || masked_eq(k_sip, e[`ACL_E_SIP +: 32],
                                 e[`ACL_E_SMSK +: 32])) &&
              (e[`ACL_E_DANY] || masked_eq(k_dip, e[`ACL_E_DIP +: 32],
                                 e[`ACL_E_DMSK +: 32])) &&
              (!e[`ACL_E_FRGEN] || (k_frag == e[`ACL_E_FRG])) && // [R8]
              (e[`ACL_E_PANY] || (k_proto == pr)) && // [R9] [R10]
              l4_ok;
      group_match = 1'b0;
      if (e[`ACL_E_VALID]) begin
        case (e[`ACL_E_TYPE +: 2])
          `ACL_TYPE_IPV4:
            group_match = vlan_ok && port_ok && ip_ok; // [R5] [R18]
          `ACL_TYPE_NONIP:
            group_match = vlan_ok && port_ok &&
              (k_etype != `ACL_ETH_IPV4) &&
              (e[`ACL_E_DANY] ||
               k_etype == e[`ACL_E_DIP +: 16]); // [R16] [R18]
          `ACL_TYPE_BIND:
            group_match = (k_etype == `ACL_ETH_IPV4) &&
              (k_sip == e[`ACL_E_SIP +: 32]) &&
              (k_mac == {e[`ACL_E_DMSK +: 16], e[`ACL_E_DIP +: 32]}) &&
              (k_vid == (e[`ACL_E_VANY] ? 12'h000 : e[`ACL_E_VID +: 12]))
              && (k_port == e[`ACL_E_INPORT +: 5]); // [R17]
          default:
            group_match = 1'b0;
        endcase
      end
    end
  endfunction

  wire [`ACL_E_W-1:0] wr_entry = {i_wr_in_port, i_wr_l4_port, i_wr_l4_any,
    i_wr_proto, i_wr_proto_any, i_wr_frag, i_wr_frag_en, i_wr_dst_mask,
    i_wr_dst_ip, i_wr_dst_any, i_wr_src_mask, i_wr_src_ip, i_wr_src_any,
    i_wr_vid, i_wr_vlan_any, i_wr_type, i_wr_action, i_wr_valid};
  localparam [31:0] LAST_IDX = `ACL_GROUPS - 1;
  wire [7:0] last   = LAST_IDX[7:0];
  wire [7:0] wr_idx = i_wr_group - 8'h01;
  // group numbers are 1..200; out-of-range writes are dropped
  wire wr_ok = i_wr_en && (i_wr_group != 8'h00) &&
               (wr_idx <= last); // [R1]
  wire hit = group_match(table_mem[idx], h_vid, h_port, h_etype, h_mac,
                         h_sip, h_dip, h_frag, h_proto, h_sl4, h_dl4);

  // reset clears every entry bit (permit, ipv4, any flags off); the any
  // defaults come from the writer, cleared groups never match
  genvar g;
  generate
    for (g = 0; g < `ACL_GROUPS; g = g + 1) begin : gen_tab
      always @(posedge i_clock) begin
        if (i_srst)
          table_mem[g] <= {`ACL_E_W{1'b0}}; // [R2] [R4]
        else if (wr_ok && wr_idx == g)
          table_mem[g] <= wr_entry;
      end
    end
  endgenerate

  always @(posedge i_clock) begin
    if (i_srst) begin
      state       <= ST_IDLE;
      idx         <= 8'h00;
      o_pkt_ready <= 1'b0;
      o_dec_valid <= 1'b0;
      o_dec_deny  <= 1'b0;
      o_dec_hit   <= 1'b0;
      o_dec_group <= 8'h00;
      h_vid <= 12'h000; h_port <= 5'h00; h_etype <= 16'h0000;
      h_mac <= 48'h0; h_sip <= 32'h0; h_dip <= 32'h0; h_frag <= 1'b0;
      h_proto <= 8'h00; h_sl4 <= 16'h0000; h_dl4 <= 16'h0000;
    end else begin
      o_dec_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_pkt_ready <= 1'b1;
          if (i_pkt_valid && o_pkt_ready) begin
            o_pkt_ready <= 1'b0;
            h_vid <= i_pkt_vid; h_port <= i_pkt_port;
            h_etype <= i_pkt_etype; h_mac <= i_pkt_src_mac;
            h_sip <= i_pkt_src_ip; h_dip <= i_pkt_dst_ip;
            h_frag <= i_pkt_frag; h_proto <= i_pkt_proto;
            h_sl4 <= i_pkt_src_l4; h_dl4 <= i_pkt_dst_l4;
            idx   <= 8'h00;
            state <= ST_SCAN;
          end
        end
        // one group per cycle trades latency for a single comparator
        ST_SCAN: begin
          if (hit) begin
            o_dec_valid <= 1'b1;
            o_dec_hit   <= 1'b1;
            o_dec_deny  <= table_mem[idx][`ACL_E_ACT]; // [R2] [R19]
            o_dec_group <= idx + 8'h01;
            state       <= ST_DONE;
          end else if (idx == last) begin
            o_dec_valid <= 1'b1;
            o_dec_hit   <= 1'b0;
            o_dec_deny  <= `ACL_ACT_PERMIT; // [R19]
            o_dec_group <= 8'h00;
            state       <= ST_DONE;
          end else begin
            idx <= idx + 8'h01; // [R19]
          end
        end
        ST_DONE: begin
          o_pkt_ready <= 1'b1;
          state       <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== inc/acl_defs.vh ====
// Behaviour
// [R1] hold up to 200 numbered rule groups
// [R2] per-group action permit or deny, reset permit
// [R3] vlan match any or specific 1..4094
// [R4] type selector ipv4, non-ipv4 or binding
// [R5] ipv4 criteria only for ipv4 groups
// [R6] source address under arbitrary bit mask
// [R7] destination address under mask, default any
// [R8] optional fragment field check, default off
// [R9] protocol any or presets icmp igmp tcp udp
// [R10] direct 8-bit protocol number compare
// [R11] tcp port any or presets ftp http
// [R12] direct 16-bit tcp port compare
// [R13] udp port any or presets dhcp tftp netbios
// [R14] direct 16-bit udp port compare
// [R15] ingress port 1..26, zero means ignored
// [R16] non-ipv4 ether-type any, presets or direct
// [R17] binding needs address, mac, vlan, port equal
// [R18] all enabled criteria combined by and
// [R19] ascending scan, first match decides, default permit
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH
`define ACL_GROUPS       200
`define ACL_IDX_W        8
`define ACL_TYPE_IPV4    2'h0
`define ACL_TYPE_NONIP   2'h1
`define ACL_TYPE_BIND    2'h2
`define ACL_ACT_PERMIT   1'b0
`define ACL_ACT_DENY     1'b1
`define ACL_PROTO_ICMP   8'h01
`define ACL_PROTO_IGMP   8'h02
`define ACL_PROTO_TCP    8'h06
`define ACL_PROTO_UDP    8'h11
`define ACL_TCP_FTP      16'h0015
`define ACL_TCP_HTTP     16'h0050
`define ACL_UDP_DHCP     16'h0043
`define ACL_UDP_TFTP     16'h0045
`define ACL_UDP_NETBIOS  16'h0089
`define ACL_ETH_ARP      16'h0806
`define ACL_ETH_IPX      16'h8137
`define ACL_ETH_IPV4     16'h0800
`define ACL_VID_MAX      12'hffe
`define ACL_PORT_MAX     5'h1a
// packed group entry layout
`define ACL_E_W          180
`define ACL_E_VALID      0
`define ACL_E_ACT        1
`define ACL_E_TYPE       2
`define ACL_E_VANY       4
`define ACL_E_VID        5
`define ACL_E_SANY       17
`define ACL_E_SIP        18
`define ACL_E_SMSK       50
`define ACL_E_DANY       82
`define ACL_E_DIP        83
`define ACL_E_DMSK       115
`define ACL_E_FRGEN      147
`define ACL_E_FRG        148
`define ACL_E_PANY       149
`define ACL_E_PROTO      150
`define ACL_E_L4ANY      158
`define ACL_E_L4PORT     159
`define ACL_E_INPORT     175
`endif

// ==== tb/acl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module acl_chk (
  input wire logic       i_clock,
  input wire logic       i_srst,
  input wire logic       i_pkt_valid,
  input wire logic       o_pkt_ready,
  input wire logic       o_dec_valid,
  input wire logic       o_dec_deny,
  input wire logic       o_dec_hit,
  input wire logic [7:0] o_dec_group
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic       tk;
  logic [7:0] cnt;
  assign tk = i_pkt_valid && o_pkt_ready;
  // edges since the last accepted header, so scan latency can be tied to k
  always_ff @(posedge i_clock) begin
    if (tk) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  property p_drop; tk |=> !o_pkt_ready; endproperty
  a_drop: assert property (p_drop) else $error("ready kept");
  property p_pulse; o_dec_valid |=> !o_dec_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_back; o_dec_valid |=> o_pkt_ready; endproperty
  a_back: assert property (p_back) else $error("no ready");
  // the pulse launched k edges after the take is seen one edge later
  property p_answer; tk |-> ##[2:201] o_dec_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_range; o_dec_hit |-> o_dec_group inside {[1:200]}; endproperty
  a_range: assert property (p_range) else $error("bad group");
  property p_nohit;
    o_dec_valid && !o_dec_hit |-> o_dec_group == 8'h00 && !o_dec_deny;
  endproperty
  a_nohit: assert property (p_nohit) else $error("miss not permit");
  property p_time;
    o_dec_valid |-> cnt == (o_dec_hit ? o_dec_group : 8'hc8);
  endproperty
  a_time: assert property (p_time) else $error("scan order");
  property p_hold;
    !o_dec_valid |-> $stable({o_dec_deny, o_dec_hit, o_dec_group});
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_idle; o_pkt_ready |-> !o_dec_valid; endproperty
  a_idle: assert property (p_idle) else $error("result while idle");
endmodule
`default_nettype wire

// ==== tb/acl_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// header source: may stall before offering, then holds valid until taken
module acl_src (
  input  wire logic       i_clock,
  input  wire logic       i_go,
  input  wire logic [1:0] i_delay,
  input  wire logic       i_ready,
  output var  logic       o_valid
);
  initial o_valid = 1'b0;
  always begin
    @(posedge i_go);
    repeat (i_delay) @(negedge i_clock);
    o_valid = 1'b1;
    @(posedge i_clock iff i_ready);
    @(negedge i_clock);
    o_valid = 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clock, i_srst, i_wr_en, i_wr_valid, i_wr_action, i_wr_vlan_any,
    i_wr_src_any, i_wr_dst_any, i_wr_frag_en, i_wr_frag, i_wr_proto_any,
    i_wr_l4_any, i_pkt_valid, o_pkt_ready, i_pkt_frag, o_dec_valid,
    o_dec_deny, o_dec_hit, go;
  logic [1:0] i_wr_type, dly;
  logic [4:0] i_wr_in_port, i_pkt_port;
  logic [7:0] i_wr_group, i_wr_proto, i_pkt_proto, o_dec_group, pr [4];
  logic [11:0] i_wr_vid, i_pkt_vid;
  logic [15:0] i_wr_l4_port, i_pkt_etype, i_pkt_src_l4, i_pkt_dst_l4,
    lp [8], et [4];
  logic [31:0] i_wr_src_ip, i_wr_src_mask, i_wr_dst_ip, i_wr_dst_mask,
    i_pkt_src_ip, i_pkt_dst_ip, seed, r;
  logic [47:0] i_pkt_src_mac;
  logic [179:0] we, t [1:200];
  logic [185:0] ph;
  int fail_count, tests_run, g;
  assign {i_wr_valid, i_wr_action, i_wr_type, i_wr_vlan_any, i_wr_vid,
    i_wr_src_any, i_wr_src_ip, i_wr_src_mask, i_wr_dst_any, i_wr_dst_ip,
    i_wr_dst_mask, i_wr_frag_en, i_wr_frag, i_wr_proto_any, i_wr_proto,
    i_wr_l4_any, i_wr_l4_port, i_wr_in_port} = we;
  assign {i_pkt_vid, i_pkt_port, i_pkt_etype, i_pkt_src_mac, i_pkt_src_ip,
    i_pkt_dst_ip, i_pkt_frag, i_pkt_proto, i_pkt_src_l4, i_pkt_dst_l4} = ph;
  packet_acl_filter u_packet_acl_filter (.*);
  acl_src u_acl_src (.i_clock(i_clock), .i_go(go), .i_delay(dly),
    .i_ready(o_pkt_ready), .o_valid(i_pkt_valid));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] gr, input logic [179:0] e);
    @(negedge i_clock);
    i_wr_en = 1'b1;
    i_wr_group = gr;
    we = e;
    if (gr >= 8'h01 && gr <= 8'hc8) t[gr] = e;
    @(negedge i_clock);
    i_wr_en = 1'b0;
  endtask
  // reference scan: lowest valid group whose criteria all hold
  function automatic int model();
    logic [179:0] e;
    logic m;
    for (int n = 1; n <= 200; n++) begin
      e = t[n];
      m = e[179] && (e[175] || e[174:163] == i_pkt_vid)
        && (e[4:0] == 5'h00 || e[4:0] == i_pkt_port);
      if (e[177:176] == 2'h0)
        m = m && i_pkt_etype == 16'h0800
          && (e[162] || ((e[161:130] ^ i_pkt_src_ip) & e[129:98]) == 0)
          && (e[97] || ((e[96:65] ^ i_pkt_dst_ip) & e[64:33]) == 0)
          && (!e[32] || e[31] == i_pkt_frag)
          && (e[30] || e[29:22] == i_pkt_proto)
          && (e[21] || ((i_pkt_proto == 8'h06 || i_pkt_proto == 8'h11)
          && (e[20:5] == i_pkt_src_l4 || e[20:5] == i_pkt_dst_l4)));
      else if (e[177:176] == 2'h1)
        m = m && i_pkt_etype != 16'h0800
          && (e[97] || e[80:65] == i_pkt_etype);
      else if (e[177:176] == 2'h2)
        m = e[179] && i_pkt_etype == 16'h0800 && e[161:130] == i_pkt_src_ip
          && {e[48:33], e[96:65]} == i_pkt_src_mac && e[4:0] == i_pkt_port
          && (e[175] ? 12'h000 : e[174:163]) == i_pkt_vid;
      else
        m = 1'b0;
      if (m) return n;
    end
    return 0;
  endfunction
  initial begin
    #(100 * 30000);
    fail_count++;
    finish_test;
  end
  initial begin
    seed = 32'hc39b8ac9;
    {fail_count, tests_run, go, dly, i_wr_en, i_wr_group, we, ph} = '0;
    i_srst = 1'b1;
    pr = '{8'h01, 8'h02, 8'h06, 8'h11};
    lp = '{16'h0015, 16'h0050, 16'h0043, 16'h0045, 16'h0089, 16'h0000,
      16'hffff, 16'h1234};
    et = '{16'h0800, 16'h0806, 16'h8137, 16'h0800};
    foreach (t[i]) t[i] = '0;
    repeat (3) @(negedge i_clock);
    i_srst = 1'b0;
    for (int k = 0; k < 40; k++) begin
      repeat (3) begin
        g = rnd() % 200 + 1;
        r = rnd();
        wr(8'(g), {r[0] | r[1], r[2], r[24] & r[25], r[3], r[4],
          12'h001 + r[5], r[6], 32'hc0a80000 + r[8:7], rnd(), r[9], 16'hc0a8,
          et[r[11:10]], rnd(), r[12] & r[13], r[14], r[15], pr[r[17:16]],
          r[18], lp[r[21:19]], 3'h0, r[23:22]});
      end
      // out-of-range numbers must not land anywhere in the table
      if (k == 5) begin
        wr(8'h00, {4'hc, {171{1'b1}}, 5'h00});
        wr(8'hc9, {4'hc, {171{1'b1}}, 5'h00});
      end
      @(negedge i_clock);
      r = rnd();
      ph = {12'h001 + r[0], 3'h0, r[2:1], et[r[4:3]], r, r[15:0],
        32'hc0a80000 + r[6:5], 16'hc0a8, et[r[8:7]], r[9], pr[r[11:10]],
        lp[r[14:12]], lp[r[17:15]]};
      dly = r[19:18];
      // a binding group built from this header, so that binding can hit
      if (r[20])
        wr(8'(rnd() % 200 + 1), {1'b1, r[21], 2'h2, r[22], 12'h001 + r[0],
          1'b0, 32'hc0a80000 + r[6:5], 32'h0, 1'b0, r[15:0], r[15:0],
          16'h0000, r[31:16], 3'h0, 8'h00, 1'b0, 16'h0000, 3'h0,
          r[2:1]});
      go = 1'b1;
      @(negedge i_clock);
      go = 1'b0;
      for (int n = 0; n < 210 && o_dec_valid !== 1'b1; n++) begin
        @(posedge i_clock);
        #1;
      end
      g = model();
      chk("answer", {7'h0, o_dec_valid}, 8'h01);
      chk("group", o_dec_group, 8'(g));
      chk("deny", {7'h0, o_dec_deny}, g ? {7'h0, t[g][178]} : 8'h00);
      chk("hit", {7'h0, o_dec_hit}, 8'(g != 0));
      $display("test %0d done", k);
    end
    finish_test;
  end
endmodule
bind packet_acl_filter acl_chk u_acl_chk (.i_clock(i_clock),
  .i_srst(i_srst), .i_pkt_valid(i_pkt_valid), .o_pkt_ready(o_pkt_ready),
  .o_dec_valid(o_dec_valid), .o_dec_deny(o_dec_deny),
  .o_dec_hit(o_dec_hit), .o_dec_group(o_dec_group));
`default_nettype wire
